//--- logic/eca_translator.sv
// configuration access translator: aperture accesses to local header, type 0 or type 1 requests
// assumes one clock (the bridge axi clock), AXI4-Lite master on the aperture, a link
// request/completion port, and a plain register port for interrupt status and mask
//
// Our own choices: the plain strobed port and the register addresses.
`include "eca_params.svh"
`timescale 1ns/100ps
`default_nettype none

module eca_translator #(
  parameter bit UPSTREAM_PORT_SELECT = 1'b0,
  parameter int ADDR_W = 28
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic cfgReqValid,
  input wire logic cfgReqReady,
  output logic cfgReqType1,
  output logic cfgReqWrite,
  output logic [7:0] cfgReqBus,
  output logic [4:0] cfgReqDev,
  output logic [2:0] cfgReqFunc,
  output logic [3:0] cfgReqExtReg,
  output logic [5:0] cfgReqReg,
  output logic [3:0] cfgReqByteEn,
  output logic [31:0] cfgReqData,
  input wire logic cplValid,
  input wire logic cplOk,
  input wire logic [31:0] cplData,
  output logic rdPktStall,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic irq
);

  eca_pkg::eca_state_t state, next_state;
  logic isWrite, next_isWrite;
  logic [1:0] resp, next_resp;
  logic [31:0] rdata, next_rdata;
  logic reqType1, next_reqType1;
  logic [7:0] reqBus, next_reqBus;
  logic [4:0] reqDev, next_reqDev;
  logic [2:0] reqFunc, next_reqFunc;
  logic [3:0] reqExt, next_reqExt;
  logic [5:0] reqReg, next_reqReg;
  logic [3:0] reqBe, next_reqBe;
  logic [31:0] reqData, next_reqData;
  logic [31:0] hdrMem [`ECA_HDR_WORDS];
  logic [31:0] next_hdrMem [`ECA_HDR_WORDS];
  logic evRange, evAbnormal;
  logic takeWrite, takeRead;
  logic [ADDR_W-1:0] accAddr;
  logic [7:0] priBus, secBus, subBus;
  logic [`ECA_IRQ_BITS-1:0] irqStatus, next_irqStatus;
  logic [`ECA_IRQ_BITS-1:0] irqMask, next_irqMask;
  logic [31:0] next_regRdata;
  logic [31:0] regRdataQ;

  // stored bus numbers from the local header steer routing
  assign priBus = hdrMem[`ECA_HDR_BUS_IDX][`ECA_PRI_LSB +: 8];
  assign secBus = hdrMem[`ECA_HDR_BUS_IDX][`ECA_SEC_LSB +: 8];
  assign subBus = hdrMem[`ECA_HDR_BUS_IDX][`ECA_SUB_LSB +: 8];

  // route of one aperture address
  function automatic eca_pkg::eca_route_t routeOf(input logic [ADDR_W-1:0] a, input logic [7:0] pri,
                                                  input logic [7:0] sec, input logic [7:0] sub);
    logic [7:0] bus;
    logic start;
    bus = a[`ECA_BUS_MSB:`ECA_BUS_LSB];
    start = (a[`ECA_BUS_MSB:`ECA_FN_LSB] == 16'h0000);
    if (UPSTREAM_PORT_SELECT) begin
      routeOf = eca_pkg::RT_LOCAL;
    end else if (bus == pri || start) begin
      routeOf = eca_pkg::RT_LOCAL;
    end else if (bus == sec) begin
      routeOf = eca_pkg::RT_TYPE0;
    end else if (bus > sec && bus <= sub) begin
      routeOf = eca_pkg::RT_TYPE1;
    end else begin
      routeOf = eca_pkg::RT_REJECT;
    end
  endfunction

  // handshakes: only idle accepts, write before read; no acceptance while frozen
  assign takeWrite = ce && (state == eca_pkg::ST_IDLE) && s_axi_awvalid && s_axi_wvalid;
  assign takeRead = ce && (state == eca_pkg::ST_IDLE) && s_axi_arvalid && !takeWrite;
  assign s_axi_awready = takeWrite;
  assign s_axi_wready = takeWrite;
  assign s_axi_arready = takeRead;
  assign accAddr = takeWrite ? s_axi_awaddr : s_axi_araddr;

  // outputs from state registers
  assign s_axi_bvalid = (state == eca_pkg::ST_RESP) && isWrite;
  assign s_axi_rvalid = (state == eca_pkg::ST_RESP) && !isWrite;
  assign s_axi_bresp = resp;
  assign s_axi_rresp = resp;
  assign s_axi_rdata = rdata;
  assign cfgReqValid = (state == eca_pkg::ST_REQ);
  assign cfgReqType1 = reqType1;
  assign cfgReqWrite = isWrite;
  assign cfgReqBus = reqBus;
  assign cfgReqDev = reqDev;
  assign cfgReqFunc = reqFunc;
  assign cfgReqExtReg = reqExt;
  assign cfgReqReg = reqReg;
  assign cfgReqByteEn = reqBe;
  assign cfgReqData = reqData;
  // a read in flight holds back other requester reads so its completion is unambiguous
  assign rdPktStall = !isWrite && (state == eca_pkg::ST_REQ || state == eca_pkg::ST_WAIT);

  // sequencer, request fields and local header
  always_comb begin
    logic [9:0] idx;
    eca_pkg::eca_route_t rt;
    idx = {accAddr[`ECA_EXT_MSB:`ECA_EXT_LSB], accAddr[`ECA_REG_MSB:`ECA_REG_LSB]};
    rt = routeOf(accAddr, priBus, secBus, subBus);
    next_state = state;
    next_isWrite = isWrite;
    next_resp = resp;
    next_rdata = rdata;
    next_reqType1 = reqType1;
    next_reqBus = reqBus;
    next_reqDev = reqDev;
    next_reqFunc = reqFunc;
    next_reqExt = reqExt;
    next_reqReg = reqReg;
    next_reqBe = reqBe;
    next_reqData = reqData;
    next_hdrMem = hdrMem;
    evRange = 1'b0;
    evAbnormal = 1'b0;
    case (state)
      eca_pkg::ST_IDLE: begin
        if (takeWrite || takeRead) begin
          next_isWrite = takeWrite;
          next_reqType1 = (rt == eca_pkg::RT_TYPE1);
          next_reqBus = accAddr[`ECA_BUS_MSB:`ECA_BUS_LSB];
          next_reqDev = accAddr[`ECA_DEV_MSB:`ECA_DEV_LSB];
          next_reqFunc = accAddr[`ECA_FN_MSB:`ECA_FN_LSB];
          next_reqExt = accAddr[`ECA_EXT_MSB:`ECA_EXT_LSB];
          next_reqReg = accAddr[`ECA_REG_MSB:`ECA_REG_LSB];
          next_reqBe = takeWrite ? s_axi_wstrb : 4'hF;
          next_reqData = s_axi_wdata;
          next_resp = `ECA_RESP_OKAY;
          next_rdata = 32'h0000_0000;
          if (rt == eca_pkg::RT_LOCAL) begin
            // device and function fields are ignored: one integrated block only
            if (idx < 10'(`ECA_HDR_WORDS)) begin
              if (takeWrite) begin
                for (int b = 0; b < 4; b++) begin
                  if (s_axi_wstrb[b]) begin
                    next_hdrMem[idx[3:0]][8*b +: 8] = s_axi_wdata[8*b +: 8];
                  end
                end
              end else begin
                next_rdata = hdrMem[idx[3:0]];
              end
            end
            next_state = eca_pkg::ST_RESP;
          end else if (rt == eca_pkg::RT_REJECT) begin
            next_resp = `ECA_RESP_SLVERR;
            evRange = 1'b1;
            next_state = eca_pkg::ST_RESP;
          end else begin
            next_state = eca_pkg::ST_REQ;
          end
        end
      end
      eca_pkg::ST_REQ: begin
        if (cfgReqReady) begin
          next_state = eca_pkg::ST_WAIT;
        end
      end
      eca_pkg::ST_WAIT: begin
        // writes are non-posted: nothing new is accepted until the completion is back
        if (cplValid) begin
          next_resp = cplOk ? `ECA_RESP_OKAY : `ECA_RESP_SLVERR;
          next_rdata = isWrite ? 32'h0000_0000 : cplData;
          evAbnormal = !cplOk;
          next_state = eca_pkg::ST_RESP;
        end
      end
      eca_pkg::ST_RESP: begin
        if ((isWrite && s_axi_bready) || (!isWrite && s_axi_rready)) begin
          next_state = eca_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = eca_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer registers; the clock is the bridge axi clock, which may stop
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= eca_pkg::ST_IDLE;
      isWrite <= 1'b0;
      resp <= `ECA_RESP_OKAY;
      rdata <= 32'h0000_0000;
      reqType1 <= 1'b0;
      reqBus <= 8'h00;
      reqDev <= 5'h00;
      reqFunc <= 3'h0;
      reqExt <= 4'h0;
      reqReg <= 6'h00;
      reqBe <= 4'h0;
      reqData <= 32'h0000_0000;
      for (int i = 0; i < `ECA_HDR_WORDS; i++) begin
        hdrMem[i] <= `ECA_HDR_RESET;
      end
    end else if (ce) begin
      state <= next_state;
      isWrite <= next_isWrite;
      resp <= next_resp;
      rdata <= next_rdata;
      reqType1 <= next_reqType1;
      reqBus <= next_reqBus;
      reqDev <= next_reqDev;
      reqFunc <= next_reqFunc;
      reqExt <= next_reqExt;
      reqReg <= next_reqReg;
      reqBe <= next_reqBe;
      reqData <= next_reqData;
      hdrMem <= next_hdrMem;
    end
  end

  // control register port: sticky events win over a write-one clear
  always_comb begin
    logic [`ECA_IRQ_BITS-1:0] ev;
    ev = '0;
    ev[`ECA_IRQ_RANGE] = evRange;
    ev[`ECA_IRQ_ABNORMAL] = evAbnormal;
    next_irqStatus = irqStatus;
    next_irqMask = irqMask;
    next_regRdata = 32'h0000_0000;
    if (regWrite && regAddr == `ECA_OFS_IRQ_STATUS) begin
      next_irqStatus = irqStatus & ~regWdata[`ECA_IRQ_BITS-1:0];
    end else if (regWrite && regAddr == `ECA_OFS_IRQ_MASK) begin
      next_irqMask = regWdata[`ECA_IRQ_BITS-1:0];
    end
    next_irqStatus = next_irqStatus | ev;
    if (regRead && regAddr == `ECA_OFS_IRQ_STATUS) begin
      next_regRdata = {30'h0, irqStatus};
    end else if (regRead && regAddr == `ECA_OFS_IRQ_MASK) begin
      next_regRdata = {30'h0, irqMask};
    end else if (regRead && regAddr == `ECA_OFS_STATE) begin
      next_regRdata = {29'h0, rdPktStall, state != eca_pkg::ST_IDLE, UPSTREAM_PORT_SELECT};
    end else if (regRead && regAddr == `ECA_OFS_BUSNUM) begin
      next_regRdata = {8'h00, subBus, secBus, priBus};
    end
  end

  // control registers; read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irqStatus <= `ECA_IRQ_RESET;
      irqMask <= `ECA_MASK_RESET;
      regRdataQ <= 32'h0000_0000;
    end else if (ce) begin
      irqStatus <= next_irqStatus;
      irqMask <= next_irqMask;
      regRdataQ <= next_regRdata;
    end
  end

  assign regRdata = regRdataQ;
  // level interrupt, usable while the aperture port is blocked
  assign irq = |(irqStatus & irqMask);

endmodule

`default_nettype wire

//--- logic/eca_params.svh
// constants of the configuration access translator: offsets, field positions, reset values
// assumes inclusion by bare name from the design file, the checker and the bench
`ifndef ECA_PARAMS_SVH
`define ECA_PARAMS_SVH

// aperture address fields
`define ECA_REG_LSB 2
`define ECA_REG_MSB 7
`define ECA_EXT_LSB 8
`define ECA_EXT_MSB 11
`define ECA_FN_LSB 12
`define ECA_FN_MSB 14
`define ECA_DEV_LSB 15
`define ECA_DEV_MSB 19
`define ECA_BUS_LSB 20
`define ECA_BUS_MSB 27

// local type 1 header: dword that holds primary, secondary, subordinate bus
`define ECA_HDR_WORDS 16
`define ECA_HDR_BUS_IDX 6
`define ECA_PRI_LSB 0
`define ECA_SEC_LSB 8
`define ECA_SUB_LSB 16
`define ECA_HDR_RESET 32'h0000_0000

// axi responses
`define ECA_RESP_OKAY 2'h0
`define ECA_RESP_SLVERR 2'h2

// control register port byte offsets
`define ECA_OFS_IRQ_STATUS 4'h0
`define ECA_OFS_IRQ_MASK 4'h4
`define ECA_OFS_STATE 4'h8
`define ECA_OFS_BUSNUM 4'hC

// interrupt status bits
`define ECA_IRQ_RANGE 0
`define ECA_IRQ_ABNORMAL 1
`define ECA_IRQ_BITS 2
`define ECA_IRQ_RESET 2'h0
`define ECA_MASK_RESET 2'h0

`endif

//--- logic/eca_pkg.sv
// types of the configuration access translator
// assumes eca_params.svh is on the include path
package eca_pkg;
  // transaction sequencer
  typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_RESP} eca_state_t;
  // where an aperture access goes
  typedef enum logic [1:0] {RT_LOCAL, RT_TYPE0, RT_TYPE1, RT_REJECT} eca_route_t;
endpackage

//--- tb/eca_translator_assertions.sv
// checker for the configuration access translator: handshake and routing relations
// assumes binding to eca_translator, watching its ports only
`include "eca_params.svh"
`timescale 1ns/100ps
`default_nettype none
module eca_translator_assertions (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic cfgReqValid,
  input wire logic cfgReqReady,
  input wire logic cplValid,
  input wire logic cplOk,
  input wire logic rdPktStall
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // a completion answers the held access in the very next cycle
  a_cpl_good_ok: assert property (ce && cplValid && cplOk |=> (s_axi_bvalid && s_axi_bresp == `ECA_RESP_OKAY)
    || (s_axi_rvalid && s_axi_rresp == `ECA_RESP_OKAY)) else $error("good completion not answered");
  a_cpl_bad_err: assert property (ce && cplValid && !cplOk |=> (s_axi_bvalid && s_axi_bresp == `ECA_RESP_SLVERR)
    || (s_axi_rvalid && s_axi_rresp == `ECA_RESP_SLVERR)) else $error("abnormal completion not flagged");
  a_req_held: assert property (cfgReqValid && !cfgReqReady |=> cfgReqValid) else $error("request dropped");
  a_link_blocks: assert property (cfgReqValid || rdPktStall |-> !s_axi_awready && !s_axi_arready)
    else $error("port open while link busy");
  a_read_route: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ^ rdPktStall)
    else $error("read neither answered nor stalled");
  a_write_route: assert property (s_axi_awready && s_axi_awvalid && s_axi_wvalid |=> s_axi_bvalid ^ cfgReqValid)
    else $error("write neither answered nor issued");
  // the stall lifts only together with the read answer
  a_stall_lift: assert property ($fell(rdPktStall) && $past(arst_n) |-> s_axi_rvalid)
    else $error("stall lifted without answer");
  a_req_once: assert property (cfgReqValid && cfgReqReady |=> !cfgReqValid [*3])
    else $error("second request too soon");
  c_link: cover property (cfgReqValid && cfgReqReady);
  c_bad: cover property (cplValid && !cplOk);
  c_reject: cover property (s_axi_bvalid && s_axi_bresp == `ECA_RESP_SLVERR);
endmodule
bind eca_translator eca_translator_assertions u_chk (.clk_sys, .arst_n, .ce, .s_axi_awvalid, .s_axi_wvalid,
  .s_axi_awready, .s_axi_arvalid, .s_axi_arready, .s_axi_bresp, .s_axi_bvalid, .s_axi_rresp, .s_axi_rvalid,
  .cfgReqValid, .cfgReqReady, .cplValid, .cplOk, .rdPktStall);
`default_nettype wire

//--- tb/eca_link_model.sv
// link-side completer model: accepts configuration requests and returns one completion each
// assumes the translator clock; slow and badCpl are set by the bench
`timescale 1ns/100ps
`default_nettype none
module eca_link_model #(
  parameter logic [31:0] DATA = 32'hC0DE_1234
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic badCpl,
  input wire logic cfgReqValid,
  output logic cfgReqReady,
  output logic cplValid,
  output logic cplOk,
  output logic [31:0] cplData
);
  logic [3:0] cnt;
  logic busy;
  // outside a completion the lines carry inverted values so nothing stale can pass
  assign cplData = cplValid ? DATA : ~DATA;
  assign cplOk = cplValid ? !badCpl : badCpl;
  // accept after a short or long pause, then complete once; one request at a time
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0;
      busy <= 1'b0;
      cfgReqReady <= 1'b0;
      cplValid <= 1'b0;
    end else begin
      cfgReqReady <= 1'b0;
      cplValid <= 1'b0;
      cnt <= cnt + 4'h1;
      if (!busy && !cfgReqValid)
        cnt <= 4'h0;
      else if (!busy && !cfgReqReady && cnt >= (slow ? 4'h3 : 4'h0)) begin
        cfgReqReady <= 1'b1;
        busy <= 1'b1;
        cnt <= 4'h0;
      end else if (busy && cnt >= (slow ? 4'h6 : 4'h1)) begin
        cplValid <= 1'b1;
        busy <= 1'b0;
        cnt <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/ecam_config_access_translator_bench.sv
// bench for the configuration access translator: routing table, interrupts, faulty completion
// assumes the link model on the far side and the checker bound to the design
`include "eca_params.svh"
`timescale 1ns/100ps
`default_nettype none
module ecam_config_access_translator_bench;
  localparam logic [31:0] CPL = 32'hC0DE_1234;
  typedef struct packed {logic w; logic [27:0] a; logic [31:0] d; logic [3:0] s; logic [1:0] r;
    logic [31:0] x; logic [32:0] q;} eca_row_t;
  logic clk_sys = 0, arst_n = 0, awV = 0, wV = 0, arV = 0, slow = 0, badCpl = 0, regWrite = 0, regRead = 0;
  logic [27:0] addr = 0;
  logic [31:0] wdata = 0, regWdata = 0, seenD, rdata, cfgReqData, cplData, regRdata;
  logic [3:0] wstrb = 0, regAddr = 0, cfgReqExtReg, cfgReqByteEn;
  logic [32:0] seenQ;
  logic [1:0] bresp, rresp;
  logic [7:0] cfgReqBus;
  logic [4:0] cfgReqDev;
  logic [2:0] cfgReqFunc;
  logic [5:0] cfgReqReg;
  logic awRdy, bV, arRdy, rV, cfgReqValid, cfgReqReady, cfgReqType1, cfgReqWrite, cplValid, cplOk, rdPktStall, irq;
  int nFail = 0, samplesChecked = 0, cyc = 0;
  eca_translator u_dut (.clk_sys, .arst_n, .ce(1'b1), .s_axi_awaddr(addr), .s_axi_awvalid(awV),
    .s_axi_awready(awRdy), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wV), .s_axi_wready(),
    .s_axi_bresp(bresp), .s_axi_bvalid(bV), .s_axi_bready(1'b1), .s_axi_araddr(addr), .s_axi_arvalid(arV),
    .s_axi_arready(arRdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rV), .s_axi_rready(1'b1),
    .cfgReqValid, .cfgReqReady, .cfgReqType1, .cfgReqWrite, .cfgReqBus, .cfgReqDev, .cfgReqFunc,
    .cfgReqExtReg, .cfgReqReg, .cfgReqByteEn, .cfgReqData, .cplValid, .cplOk, .cplData, .rdPktStall,
    .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .irq);
  eca_link_model #(.DATA(CPL)) u_link (.clk_sys, .arst_n, .slow, .badCpl, .cfgReqValid, .cfgReqReady,
    .cplValid, .cplOk, .cplData);
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // capture each request as the link takes it
  always @(posedge clk_sys) begin
    if (cfgReqValid && cfgReqReady) begin
      seenQ <= {1'b1, cfgReqType1, cfgReqWrite, cfgReqBus, cfgReqDev, cfgReqFunc, cfgReqExtReg, cfgReqReg,
        cfgReqByteEn};
      seenD <= cfgReqData;
    end
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      nFail++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one aperture access; read data for reads, link write data for writes
  task automatic ax(input eca_row_t t);
    int n;
    seenQ <= '0;
    seenD <= '0;
    addr <= t.a;
    wdata <= t.d;
    wstrb <= t.s;
    awV <= t.w;
    wV <= t.w;
    arV <= !t.w;
    n = 0;
    // ready is combinational: look at it mid-cycle, release only after the taking edge
    do begin
      @(negedge clk_sys);
      n++;
    end while (!(t.w ? awRdy : arRdy) && n < 40);
    @(posedge clk_sys);
    awV <= 0;
    wV <= 0;
    arV <= 0;
    // the answer stands until the next edge, so compare it mid-cycle
    do begin
      @(negedge clk_sys);
      n++;
    end while (!(t.w ? bV : rV) && n < 80);
    chk(t.w ? bresp : rresp, t.r);
    chk(t.w ? seenD : rdata, t.x);
    chk(seenQ, t.q);
    @(posedge clk_sys);
  endtask
  task automatic rg(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    regAddr <= a;
    regWdata <= d;
    regWrite <= w;
    regRead <= !w;
    @(posedge clk_sys);
    regWrite <= 0;
    regRead <= 0;
    // read data stands for this one cycle only
    @(negedge clk_sys);
    q = regRdata;
    @(posedge clk_sys);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    eca_row_t rows [7];
    logic [31:0] v;
    // bus numbers primary 0, secondary 1, subordinate 5 go in first through the aperture start
    rows = '{'{1, 28'h0000018, 32'h0005_0100, 4'hF, 2'h0, 0, 0},
      '{0, 28'h001D01B, 0, 0, 2'h0, 32'h0005_0100, 0},
      '{0, 28'h0111314, 0, 0, 2'h0, CPL, {3'b100, 8'h01, 5'd2, 3'd1, 4'd3, 6'd5, 4'hF}},
      '{1, 28'h050002E, 32'h1234_ABCD, 4'h6, 2'h0, 32'h1234_ABCD, {3'b111, 8'h05, 5'd0, 3'd0, 4'd0, 6'd11, 4'h6}},
      '{1, 28'h0600000, 32'h1, 4'hF, 2'h2, 0, 0},
      '{0, 28'h03FFFFC, 0, 0, 2'h0, CPL, {3'b110, 8'h03, 5'd31, 3'd7, 4'hF, 6'd63, 4'hF}},
      '{0, 28'h0FF0000, 0, 0, 2'h2, 0, 0}};
    repeat (4) @(posedge clk_sys);
    arst_n <= 1;
    @(posedge clk_sys);
    foreach (rows[i]) ax(rows[i]);
    $display("routing rows done");
    rg(0, `ECA_OFS_IRQ_STATUS, 0, v);
    chk(v, 32'h1);
    rg(1, `ECA_OFS_IRQ_MASK, 32'h3, v);
    @(posedge clk_sys);
    chk(irq, 1'b1);
    rg(1, `ECA_OFS_IRQ_STATUS, 32'h1, v);
    rg(0, `ECA_OFS_IRQ_STATUS, 0, v);
    chk({irq, v}, 33'h0);
    rg(0, `ECA_OFS_BUSNUM, 0, v);
    chk(v, 32'h0005_0100);
    rg(0, 4'h2, 0, v);
    chk(v, 32'h0);
    $display("interrupt tests done");
    // slow link answering a write abnormally
    slow <= 1;
    badCpl <= 1;
    ax('{1, 28'h0100000, 32'h5A, 4'hF, 2'h2, 32'h5A, {3'b101, 8'h01, 5'd0, 3'd0, 4'd0, 6'd0, 4'hF}});
    rg(0, `ECA_OFS_IRQ_STATUS, 0, v);
    chk({irq, v}, {1'b1, 32'h2});
    rg(1, `ECA_OFS_IRQ_MASK, 32'h0, v);
    @(posedge clk_sys);
    chk(irq, 1'b0);
    $display("fault tests done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
